// ### uil_pkg.sv
// Constants and carrier types of the serial port interrupt logic
//
// Contract
// - Five independent source enables, bits 4..0
// - Line status errors raise line interrupt
// - FIFO mode: check bottom character only
// - Line status read clears line interrupt
// - Non-FIFO mode: check buffered character errors
// - FIFO mode: data available at trigger
// - FIFO mode: data available drops below trigger
// - Non-FIFO: data available when buffer full
// - Non-FIFO: buffer read clears data available
// - Time-out only in FIFO mode
// - Time-out after four idle character times
// - FIFO read or flush clears time-out
// - Active time-out: only reads or flushes restart counter
// - Idle time-out: reads or arrivals restart
// - Non-FIFO: empty holding register requests data
// - Non-FIFO: identification read or write clears
// - FIFO mode: request at 32 or fewer
// - FIFO mode: identification read or write clears
// - Modem status bit rising raises interrupt
// - Modem status read clears modem interrupt
// - Enable bit gates its source
// - Trigger field selects 1, 8, 16, 32
// - Control bit 0 selects FIFO mode
// - Enable bit 6 is unit enable
package uil_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_IER = 8'h04;
    localparam logic [7:0] OFS_IIR = 8'h08;
    localparam logic [7:0] OFS_FCR = 8'h0c;
    localparam logic [7:0] OFS_LSR = 8'h14;
    localparam logic [7:0] OFS_MSR = 8'h18;
    localparam logic [7:0] OFS_CFG = 8'h20;
    // Field positions
    localparam int BIT_RX_AVAILABLE_EN = 0;
    localparam int BIT_TX_REQUEST_EN = 1;
    localparam int BIT_RX_LINE_STATUS_EN = 2;
    localparam int BIT_MODEM_STATUS_EN = 3;
    localparam int BIT_RX_TIMEOUT_EN = 4;
    localparam int BIT_UNIT_ENABLE = 6;
    localparam int BIT_FIFO_MODE = 0;
    localparam int BIT_RX_FLUSH = 1;
    localparam int BIT_TX_FLUSH = 2;
    localparam int BIT_TRIG_LSB = 6;
    // Reset values and masks
    localparam logic [7:0] IER_RESET = 8'h00;
    localparam logic [7:0] IER_MASK = 8'h5f;
    localparam logic [15:0] DIV_RESET = 16'h0001;
    localparam logic [3:0] FRAME_RESET = 4'ha;
    // Identification codes, low nibble
    localparam logic [3:0] IIR_NONE = 4'h1;
    localparam logic [3:0] IIR_LINE = 4'h6;
    localparam logic [3:0] IIR_AVAIL = 4'h4;
    localparam logic [3:0] IIR_TIMEOUT = 4'hc;
    localparam logic [3:0] IIR_TXREQ = 4'h2;
    localparam logic [3:0] IIR_MODEM = 4'h0;
    // Counts
    localparam int FIFO_DEPTH = 64;
    localparam int TX_REQ_LEVEL = 32;
    localparam int TRIG_0 = 1;
    localparam int TRIG_1 = 8;
    localparam int TRIG_2 = 16;
    localparam int TRIG_3 = 32;
    localparam int OVERSAMPLE = 16;
    localparam int TIMEOUT_CHARS = 4;

    typedef struct packed {
        logic fifo_err;
        logic brk;
        logic framing;
        logic parity;
        logic overrun;
    } uil_line_err_t;

    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } uil_modem_t;

    typedef enum {CAUSE_NONE, CAUSE_LINE, CAUSE_AVAIL, CAUSE_TIMEOUT,
                  CAUSE_TXREQ, CAUSE_MODEM} uil_cause_t;
endpackage : uil_pkg

// ### uil_sticky.sv
// Sticky flag vector where a set beats a clear
`timescale 1ns/1ps
module uil_sticky #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    // Set wins so an event landing on the clear cycle survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= (q & ~clr) | set;
        end
    end

    AST_STICKY_SET: assert property (@(posedge pclk) disable iff (!presetn)
        set != '0 |=> (q & $past(set)) == $past(set))
        else $error("sticky bit lost its set");
endmodule : uil_sticky

// ### uil_rx_timeout.sv
// Receive character time-out counter
`timescale 1ns/1ps
module uil_rx_timeout (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    input wire logic nonempty,
    input wire logic push,
    input wire logic pop,
    input wire logic flush,
    input wire logic [15:0] divisor,
    input wire logic [3:0] frame_bits,
    output logic timeout
);
    import uil_pkg::*;

    logic [19:0] pre;
    logic [19:0] bit_len;
    logic [6:0] bits;
    logic [6:0] limit;
    logic restart;

    // Bit time is divisor times oversampling; zero divisor acts as one
    assign bit_len = 20'(divisor == 16'h0000 ? 16'h0001 : divisor) * 20'(OVERSAMPLE);
    assign limit = 7'(TIMEOUT_CHARS) * {3'h0, frame_bits};
    // Arrivals only restart while idle, reads always do
    assign restart = !en || !nonempty || pop || flush || (push && !timeout);

    // Prescaler and elapsed bit counter, frozen once expired
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= '0;
            bits <= '0;
        end else if (restart) begin
            pre <= '0;
            bits <= '0;
        end else if (!timeout && bits != limit) begin
            if (pre == bit_len - 20'h00001) begin
                pre <= '0;
                bits <= bits + 7'h01;
            end else begin
                pre <= pre + 20'h00001;
            end
        end
    end

    // Expiry flag, FIFO mode only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout <= 1'b0;
        end else if (!en || !nonempty || pop || flush) begin
            timeout <= 1'b0;
        end else if (bits == limit && limit != 7'h00) begin
            timeout <= 1'b1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_TO_HOLD: assert property (timeout && push && !pop && !flush && en && nonempty
        |=> timeout) else $error("arrival cleared active time-out");
    AST_TO_CLEAR: assert property ((pop || flush) |=> !timeout)
        else $error("time-out survived read or flush");
    AST_TO_RESTART: assert property (!timeout && push |=> bits == 7'h00)
        else $error("arrival did not restart counter");
    AST_TO_FIFO_ONLY: assert property (!en |=> !timeout)
        else $error("time-out outside FIFO mode");
endmodule : uil_rx_timeout

// ### uil_irq_ctrl.sv
// Serial port interrupt logic with APB register access
`timescale 1ns/1ps
module uil_irq_ctrl #(
    parameter int DEPTH = uil_pkg::FIFO_DEPTH,
    parameter int TX_LEVEL = uil_pkg::TX_REQ_LEVEL,
    parameter int CW = $clog2(uil_pkg::FIFO_DEPTH + 1)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] rx_data,
    input wire logic [CW-1:0] rx_count,
    input wire logic rx_push,
    input wire logic rx_bottom_new,
    input wire uil_pkg::uil_line_err_t rx_bottom_err,
    input wire logic [CW-1:0] tx_count,
    input wire logic thr_empty,
    input wire logic tx_idle,
    input wire uil_pkg::uil_modem_t modem,
    output logic rx_pop,
    output logic tx_push,
    output logic [7:0] tx_data,
    output logic rx_flush,
    output logic tx_flush,
    output logic fifo_mode,
    output logic unit_enable,
    output logic irq
);
    import uil_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] interrupt_enable;
    logic [1:0] trig_sel;
    logic [15:0] divisor;
    logic [3:0] frame_bits;
    logic access;
    logic setup;
    logic addr_ok;
    logic wr_ier;
    logic wr_fcr;
    logic wr_cfg;
    logic wr_data;
    logic rd_data;
    logic rd_iir;
    logic rd_lsr;
    logic rd_msr;
    logic [31:0] next_prdata;
    logic rx_available_irq_en;
    logic tx_request_irq_en;
    logic rx_line_status_irq_en;
    logic modem_status_irq_en;
    logic rx_timeout_irq_en;
    logic [CW-1:0] trig_level;
    logic avail;
    logic tx_cond;
    logic tx_cond_q;
    logic tx_req;
    logic timeout;
    logic [4:0] line_set;
    logic [4:0] line_clr;
    logic [4:0] line_err;
    logic [3:0] ms_set;
    logic [3:0] ms_clr;
    logic [3:0] ms_delta;
    uil_modem_t modem_q;
    logic p_line;
    logic p_avail;
    logic p_to;
    logic p_tx;
    logic p_modem;
    uil_cause_t cause;
    logic [3:0] iir_code;
    logic [7:0] lsr;
    logic [7:0] msr;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    // No wait states: read data is captured in the setup cycle
    assign pready = 1'b1;
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pslverr = access && !addr_ok;

    // Address check and access strobes, all on the access edge
    always_comb begin
        addr_ok = 1'b0;
        case (paddr)
            OFS_DATA, OFS_IER, OFS_IIR, OFS_FCR,
            OFS_LSR, OFS_MSR, OFS_CFG: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    assign wr_ier = access && pwrite && paddr == OFS_IER;
    assign wr_fcr = access && pwrite && paddr == OFS_FCR;
    assign wr_cfg = access && pwrite && paddr == OFS_CFG;
    assign wr_data = access && pwrite && paddr == OFS_DATA;
    assign rd_data = access && !pwrite && paddr == OFS_DATA;
    assign rd_iir = access && !pwrite && paddr == OFS_IIR;
    assign rd_lsr = access && !pwrite && paddr == OFS_LSR;
    assign rd_msr = access && !pwrite && paddr == OFS_MSR;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Bits 7 and 5 are not implemented and read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_enable <= IER_RESET;
        end else if (wr_ier) begin
            interrupt_enable <= pwdata[7:0] & IER_MASK;
        end
    end

    assign rx_available_irq_en = interrupt_enable[BIT_RX_AVAILABLE_EN];
    assign tx_request_irq_en = interrupt_enable[BIT_TX_REQUEST_EN];
    assign rx_line_status_irq_en = interrupt_enable[BIT_RX_LINE_STATUS_EN];
    assign modem_status_irq_en = interrupt_enable[BIT_MODEM_STATUS_EN];
    assign rx_timeout_irq_en = interrupt_enable[BIT_RX_TIMEOUT_EN];

    // Unit enable is a registered copy of its bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_enable <= 1'b0;
        end else if (wr_ier) begin
            unit_enable <= pwdata[BIT_UNIT_ENABLE];
        end
    end

    // Mode select and trigger field; flush bits are not stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_mode <= 1'b0;
            trig_sel <= 2'h0;
        end else if (wr_fcr) begin
            fifo_mode <= pwdata[BIT_FIFO_MODE];
            trig_sel <= pwdata[BIT_TRIG_LSB+:2];
        end
    end

    // Character timing configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divisor <= DIV_RESET;
            frame_bits <= FRAME_RESET;
        end else if (wr_cfg) begin
            divisor <= pwdata[15:0];
            frame_bits <= pwdata[19:16];
        end
    end

    // Flush pulses are high for the one cycle after the write, then clear themselves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_flush <= 1'b0;
            tx_flush <= 1'b0;
        end else begin
            rx_flush <= wr_fcr && pwdata[BIT_RX_FLUSH];
            tx_flush <= wr_fcr && pwdata[BIT_TX_FLUSH];
        end
    end

    // Data path strobes toward the FIFOs or buffer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_pop <= 1'b0;
            tx_push <= 1'b0;
            tx_data <= 8'h00;
        end else begin
            rx_pop <= rd_data;
            tx_push <= wr_data;
            if (wr_data) begin
                tx_data <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt sources
    // ----------------------------------------------------------------
    // Errors of the character now at the bottom, or in the buffer
    assign line_set = (unit_enable && rx_bottom_new) ? rx_bottom_err : 5'h00;
    // Only bits that the read actually returned are cleared
    assign line_clr = rd_lsr ? {prdata[7], prdata[4:1]} : 5'h00;

    uil_sticky #(.W(5)) u_line (
        .pclk(pclk),
        .presetn(presetn),
        .set(line_set),
        .clr(line_clr),
        .q(line_err)
    );

    // Trigger level decode
    always_comb begin
        case (trig_sel)
            2'h0: trig_level = CW'(TRIG_0);
            2'h1: trig_level = CW'(TRIG_1);
            2'h2: trig_level = CW'(TRIG_2);
            2'h3: trig_level = CW'(TRIG_3);
            default: trig_level = CW'(TRIG_0);
        endcase
    end

    // Level source: follows the count, so it falls by itself
    assign avail = fifo_mode ? (rx_count >= trig_level)
                             : (rx_count != '0);

    uil_rx_timeout u_timeout (
        .pclk(pclk),
        .presetn(presetn),
        .en(fifo_mode && unit_enable),
        .nonempty(rx_count != '0),
        .push(rx_push),
        .pop(rd_data),
        .flush(wr_fcr && pwdata[BIT_RX_FLUSH]),
        .divisor(divisor),
        .frame_bits(frame_bits),
        .timeout(timeout)
    );

    // Transmit request condition differs by mode
    assign tx_cond = fifo_mode ? (tx_count <= CW'(TX_LEVEL)) : thr_empty;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cond_q <= 1'b0;
        end else begin
            tx_cond_q <= tx_cond;
        end
    end

    // Edge-set, so a read of the identification register silences it
    uil_sticky #(.W(1)) u_txreq (
        .pclk(pclk),
        .presetn(presetn),
        .set(unit_enable && tx_cond && !tx_cond_q),
        .clr(rd_iir || wr_data),
        .q(tx_req)
    );

    // Previous modem levels for rising detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modem_q <= '0;
        end else begin
            modem_q <= modem;
        end
    end

    assign ms_set = unit_enable ? (modem & ~modem_q) : 4'h0;
    assign ms_clr = rd_msr ? prdata[3:0] : 4'h0;

    uil_sticky #(.W(4)) u_modem (
        .pclk(pclk),
        .presetn(presetn),
        .set(ms_set),
        .clr(ms_clr),
        .q(ms_delta)
    );

    // ----------------------------------------------------------------
    // Gating, priority and request
    // ----------------------------------------------------------------
    assign p_line = rx_line_status_irq_en && line_err != 5'h00;
    assign p_avail = rx_available_irq_en && avail;
    assign p_to = rx_timeout_irq_en && timeout;
    assign p_tx = tx_request_irq_en && tx_req;
    assign p_modem = modem_status_irq_en && ms_delta != 4'h0;

    // Highest priority pending cause shown in identification
    always_comb begin
        if (p_line) begin
            cause = CAUSE_LINE;
        end else if (p_avail) begin
            cause = CAUSE_AVAIL;
        end else if (p_to) begin
            cause = CAUSE_TIMEOUT;
        end else if (p_tx) begin
            cause = CAUSE_TXREQ;
        end else if (p_modem) begin
            cause = CAUSE_MODEM;
        end else begin
            cause = CAUSE_NONE;
        end
        if (!unit_enable) begin
            cause = CAUSE_NONE;
        end
    end

    always_comb begin
        case (cause)
            CAUSE_LINE: iir_code = IIR_LINE;
            CAUSE_AVAIL: iir_code = IIR_AVAIL;
            CAUSE_TIMEOUT: iir_code = IIR_TIMEOUT;
            CAUSE_TXREQ: iir_code = IIR_TXREQ;
            CAUSE_MODEM: iir_code = IIR_MODEM;
            default: iir_code = IIR_NONE;
        endcase
    end

    // One request line, registered to keep it glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= unit_enable && (p_line || p_avail || p_to || p_tx || p_modem);
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    assign lsr = {line_err[4], tx_idle, tx_cond, line_err[3:0], rx_count != '0};
    assign msr = {modem, ms_delta};

    always_comb begin
        case (paddr)
            OFS_DATA: next_prdata = {24'h000000, rx_data};
            OFS_IER: next_prdata = {24'h000000, interrupt_enable | {1'b0, unit_enable, 6'h00}};
            OFS_IIR: next_prdata = {24'h000000, fifo_mode, fifo_mode, 2'h0, iir_code};
            OFS_FCR: next_prdata = {24'h000000, trig_sel, 5'h00, fifo_mode};
            OFS_LSR: next_prdata = {24'h000000, lsr};
            OFS_MSR: next_prdata = {24'h000000, msr};
            OFS_CFG: next_prdata = {12'h000, frame_bits, divisor};
            default: next_prdata = 32'h00000000;
        endcase
    end

    // Snapshot at setup holds steady through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            prdata <= pwrite ? 32'h00000000 : next_prdata;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_ENABLES_OFF: assert property (interrupt_enable[4:0] == 5'h00 |=> !irq)
        else $error("request with all sources disabled");
    AST_UNIT_OFF: assert property (!unit_enable |=> !irq)
        else $error("request while unit disabled");
    AST_LINE_SET: assert property (unit_enable && rx_bottom_new && rx_bottom_err != 5'h00
        && rx_line_status_irq_en |=> ##1 irq) else $error("line error not signalled");
    AST_LINE_CLR: assert property (rd_lsr && line_set == 5'h00
        |=> (line_err & $past(line_clr)) == 5'h00) else $error("line status read kept error");
    AST_AVAIL_FIFO: assert property (fifo_mode && rx_count >= trig_level
        && rx_available_irq_en && unit_enable |=> irq) else $error("trigger reached, no request");
    AST_AVAIL_BELOW: assert property (fifo_mode && rx_count < trig_level
        && interrupt_enable[4:0] == 5'h01 |=> !irq) else $error("data available below trigger");
    AST_AVAIL_BUF: assert property (!fifo_mode && rx_count != '0
        && rx_available_irq_en && unit_enable |=> irq) else $error("full buffer, no request");
    AST_TO_NONFIFO: assert property (!fifo_mode |=> !timeout)
        else $error("time-out in non-FIFO mode");
    AST_TX_CLR: assert property ((rd_iir || wr_data) && !(unit_enable && tx_cond && !tx_cond_q)
        |=> !tx_req) else $error("transmit request not cleared");
    AST_TX_LEVEL: assert property (fifo_mode && unit_enable && $fell(tx_count > CW'(TX_LEVEL))
        |=> tx_req) else $error("half empty without request");
    AST_MS_SET: assert property (unit_enable && $rose(modem.cts) |=> ms_delta[0])
        else $error("modem change missed");
    AST_MS_CLR: assert property (rd_msr && ms_set == 4'h0 |=> (ms_delta & $past(ms_clr)) == 4'h0)
        else $error("modem status read kept delta");
    AST_TRIG: assert property (trig_sel == 2'h3 |-> trig_level == CW'(TRIG_3))
        else $error("wrong trigger level");

    COV_TIMEOUT_IRQ: cover property (p_to && cause == CAUSE_TIMEOUT ##1 irq);
    COV_LINE_IRQ: cover property (p_line ##1 irq ##[1:20] rd_lsr);
    COV_TX_IRQ: cover property (p_tx ##1 irq ##[1:20] rd_iir);
    COV_MODEM_IRQ: cover property (p_modem ##[1:20] rd_msr);
endmodule : uil_irq_ctrl

// ### uil_apb_host.sv
// APB host model standing in for the processor
`timescale 1ns/1ps
module uil_apb_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One transfer; released address and write data show inverted values, not stale ones
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : uil_apb_host

// ### uil_irq_ctrl_test.sv
// Register-level test of the serial port interrupt logic
`timescale 1ns/1ps
module uil_irq_ctrl_test;
    import uil_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, rx_data;
    logic [31:0] pwdata, prdata;
    logic [6:0] rx_count, tx_count;
    logic rx_push, rx_bottom_new, thr_empty, tx_idle, rx_pop;
    logic tx_push, rx_flush, fifo_mode;
    logic [7:0] tx_data;
    uil_line_err_t rx_bottom_err;
    uil_modem_t modem;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    uil_irq_ctrl u_uil_irq_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_data(rx_data),
        .rx_count(rx_count), .rx_push(rx_push), .rx_bottom_new(rx_bottom_new),
        .rx_bottom_err(rx_bottom_err), .tx_count(tx_count), .thr_empty(thr_empty),
        .tx_idle(tx_idle), .modem(modem), .rx_pop(rx_pop), .tx_push(tx_push),
        .tx_data(tx_data), .rx_flush(rx_flush), .tx_flush(), .fifo_mode(fifo_mode),
        .unit_enable(),
        .irq(irq));
    uil_apb_host u_uil_apb_host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    // ----------------------------------------------------------------
    // Clock, watchdog and checking helpers
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Whole sequence needs well under 2000 cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            test_done();
        end
    end
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t reg got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t flag got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        u_uil_apb_host.xfer(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        u_uil_apb_host.xfer(1'b0, a, 32'h0, r, e);
        chk_reg(r, exp);
    endtask : rd
    // Irq settles within two edges of its cause
    task automatic irq_is(input logic e);
        repeat (3) @(posedge pclk);
        #1;
        chk_bit(irq, e);
    endtask : irq_is
    task automatic test_done();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    // Buffer side answers a data read by emptying
    always @(posedge pclk) if (rx_pop && !u_uil_irq_ctrl.fifo_mode) rx_count <= 7'h0;
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic e;
        presetn = 1'b0;
        {rx_data, rx_count, tx_count} = {8'h5a, 7'h0, 7'h28};
        {rx_push, rx_bottom_new, thr_empty, tx_idle} = 4'h0;
        rx_bottom_err = '0;
        modem = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_IER, 32'h0);
        rd(OFS_IIR, 32'h01);
        wr(OFS_IER, 32'hff);
        rd(OFS_IER, 32'h5f);
        u_uil_apb_host.xfer(1'b0, 8'h30, 32'h0, r, e);
        chk_bit(e, 1'b1);
        wr(OFS_IER, 32'h48);
        modem <= 4'h1;
        irq_is(1'b1);
        rd(OFS_IIR, 32'h00);
        rd(OFS_MSR, 32'h11);
        irq_is(1'b0);
        wr(OFS_IER, 32'h40);
        modem <= 4'h3;
        irq_is(1'b0);
        rd(OFS_MSR, 32'h32);
        wr(OFS_IER, 32'h44);
        rx_bottom_err <= 5'h02;
        rx_bottom_new <= 1'b1;
        @(posedge pclk) rx_bottom_new <= 1'b0;
        irq_is(1'b1);
        rd(OFS_IIR, 32'h06);
        rd(OFS_LSR, 32'h04);
        irq_is(1'b0);
        wr(OFS_IER, 32'h41);
        rx_count <= 7'h1;
        irq_is(1'b1);
        rd(OFS_DATA, 32'h5a);
        irq_is(1'b0);
        wr(OFS_FCR, 32'h41);
        rx_count <= 7'h7;
        irq_is(1'b0);
        rx_count <= 7'h8;
        irq_is(1'b1);
        rd(OFS_IIR, 32'hc4);
        rx_count <= 7'h7;
        irq_is(1'b0);
        wr(OFS_IER, 32'h42);
        tx_count <= 7'h20;
        irq_is(1'b1);
        rd(OFS_IIR, 32'hc2);
        irq_is(1'b0);
        // Divisor 1, two-bit frame: time-out after 128 idle cycles
        wr(OFS_CFG, 32'h00020001);
        wr(OFS_IER, 32'h50);
        rx_count <= 7'h1;
        rx_push <= 1'b1;
        @(posedge pclk) rx_push <= 1'b0;
        repeat (112) @(posedge pclk);
        irq_is(1'b0);
        repeat (22) @(posedge pclk);
        irq_is(1'b1);
        rd(OFS_IIR, 32'hcc);
        rd(OFS_DATA, 32'h5a);
        irq_is(1'b0);
        // Strobes toward the FIFOs, seen just after the access edge
        wr(OFS_DATA, 32'ha5);
        #1;
        chk_bit(tx_push, 1'b1);
        chk_reg({24'h0, tx_data}, 32'ha5);
        wr(OFS_FCR, 32'h43);
        #1;
        chk_bit(rx_flush, 1'b1);
        chk_bit(fifo_mode, 1'b1);
        test_done();
    end
endmodule : uil_irq_ctrl_test
